//--- common/agc_cfg.svh
// offsets, field positions, reset values and timing counts of the config bank
`ifndef AGC_CFG_SVH
`define AGC_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (7-bit SPI address space)
// ----------------------------------------------------------------------
`define AGC_OFS_FILT 7'h12
`define AGC_OFS_SARPIN 7'h13
`define AGC_OFS_FMT 7'h14
`define AGC_OFS_REFMTR 7'h15
`define AGC_OFS_SARDIAG 7'h16
`define AGC_NUM_REGS 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define AGC_RST_FILT 8'h09
`define AGC_RST_SARPIN 8'h80
`define AGC_RST_FMT 8'h20
`define AGC_RST_REFMTR 8'h00
`define AGC_RST_SARDIAG 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AGC_FILT_SINC5_BIT 6
`define AGC_FILT_SARRB_BIT 5
`define AGC_FILT_SDODRV_HI 4
`define AGC_FILT_SDODRV_LO 3
`define AGC_FILT_LANEDRV_HI 2
`define AGC_FILT_LANEDRV_LO 1
`define AGC_FILT_SYNC_BIT 0
`define AGC_SARPIN_DGL_HI 7
`define AGC_SARPIN_DGL_LO 6
`define AGC_SARPIN_ADCRB_BIT 4
`define AGC_SARPIN_CKBYP_BIT 0
`define AGC_FMT_LANE_HI 7
`define AGC_FMT_LANE_LO 6
`define AGC_FMT_CRC_BIT 5
`define AGC_FMT_DIV_HI 3
`define AGC_FMT_DIV_LO 1
`define AGC_REF_HI 7
`define AGC_REF_LO 6
`define AGC_MTR_HI 5
`define AGC_MTR_LO 2
`define AGC_SARMUX_HI 7
`define AGC_SARMUX_LO 3

// ----------------------------------------------------------------------
// codes
// ----------------------------------------------------------------------
`define AGC_DGL_NONE 2'h3
`define AGC_LANES_4 3'h4
`define AGC_LANES_2 3'h2
`define AGC_LANES_1 3'h1

// ----------------------------------------------------------------------
// timing: deglitch of 1.5 clock periods, rounded up to whole cycles
// ----------------------------------------------------------------------
`define AGC_CLK_HZ 20000000
`define AGC_DGL_TENTH_PERIODS 15
`define AGC_DGL_CYC ((`AGC_DGL_TENTH_PERIODS + 9) / 10)
`define AGC_MCLK_MIN_KHZ 265

`endif

//--- common/agc_div_if.sv
// data clock divider control between the bank and its divider
`timescale 1ns/10ps
interface agc_div_if;
    logic [2:0] div_code;
    logic tick;
    modport ctl (output div_code, input tick);
    modport div (input div_code, output tick);
endinterface : agc_div_if

//--- common/agc_pkg.sv
// types shared by the config bank modules
package agc_pkg;
    typedef enum logic [1:0] {
        AGC_IDLE,
        AGC_CMD,
        AGC_DATA,
        AGC_DONE
    } agc_spi_state_t;
    typedef logic [7:0] agc_byte_t;
endpackage : agc_pkg

//--- src/agc_clk_div.sv
// divides the master clock by two to the power of the divider code
`timescale 1ns/10ps
`include "agc_cfg.svh"
module agc_clk_div
    import agc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    agc_div_if.div dv
);
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    logic [6:0] mask;

    always_comb begin
        mask = 7'((8'h01 << dv.div_code) - 8'h01);
        // code 000 gives a tick every cycle
        if ((cnt_reg & mask) == mask) begin
            cnt_next = 7'h00;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 7'h01;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign dv.tick = tick_reg;

    div_period_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (dv.div_code == 3'h1 && $stable(dv.div_code)) && tick_reg
        |=> !tick_reg)
        else $error("divide by two ticked twice in a row");
endmodule : agc_clk_div

//--- src/agc_regs.sv
// general configuration register bank with its SPI port
// ----------------------------------------------------------------------
// Summary of operation
// - filter bit low selects sinc3, high selects sinc5; resets low.
// - SAR readback bit routes SAR result onto serial data out.
// - sync output is software sync bit ANDed with start pin.
// - deglitch code 10 filters conversion start, 11 passes it.
// - ADC readback bit puts conversion results on serial data out.
// - clock check bypass bit forces master clock accepted.
// - lane field selects four, two or one data lanes.
// - header bit selects status header low, CRC header high.
// - data clock is master clock divided by two to field value.
// - reference field picks external, internal, supply or inverted.
// - meter field routes diagnostic source to converter inputs.
// - SAR mux field picks the SAR converter source pair.
// ----------------------------------------------------------------------
`timescale 1ns/10ps
`include "agc_cfg.svh"
module agc_regs
    import agc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic spi_cs_b_i,
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    input wire logic start_pin_b_i,
    input wire logic sar_conv_start_pin_i,
    input wire logic mclk_valid_i,
    input wire logic sar_result_bit_i,
    input wire logic adc_result_bit_i,
    output logic serial_data_out_o,
    output logic filter_sinc5_o,
    output logic sar_readback_enable_o,
    output logic adc_readback_enable_o,
    output logic sync_in_b_o,
    output logic conv_start_o,
    output logic clock_ok_o,
    output logic [2:0] active_lanes_o,
    output logic header_crc_o,
    output logic data_clock_tick_o,
    output logic [1:0] serial_out_drive_level_o,
    output logic [1:0] lane_drive_level_o,
    output logic [1:0] ref_sel_o,
    output logic [3:0] meter_source_sel_o,
    output logic [4:0] sar_mux_sel_o
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] cs_s, sck_s, mosi_s, start_s, conv_s, mclk_s;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_s <= 3'h7;
            sck_s <= 3'h0;
            mosi_s <= 3'h0;
            start_s <= 3'h0;
            conv_s <= 3'h0;
            mclk_s <= 3'h0;
        end else begin
            cs_s <= {cs_s[1:0], spi_cs_b_i};
            sck_s <= {sck_s[1:0], spi_sclk_i};
            mosi_s <= {mosi_s[1:0], spi_mosi_i};
            start_s <= {start_s[1:0], start_pin_b_i};
            conv_s <= {conv_s[1:0], sar_conv_start_pin_i};
            mclk_s <= {mclk_s[1:0], mclk_valid_i};
        end
    end

    logic sck_rise, sck_fall;
    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];

    // ------------------------------------------------------------------
    // SPI frame and register file
    // ------------------------------------------------------------------
    agc_spi_state_t state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    agc_byte_t shin_reg, shin_next;
    agc_byte_t shout_reg, shout_next;
    agc_byte_t cmd_reg, cmd_next;
    agc_byte_t regs_reg [`AGC_NUM_REGS];
    agc_byte_t regs_next [`AGC_NUM_REGS];
    agc_byte_t rx_byte;
    logic [6:0] rx_idx7, cmd_idx7;
    logic rx_hit, cmd_hit;

    assign rx_byte = {shin_reg[6:0], mosi_s[1]};
    assign rx_idx7 = rx_byte[6:0] - `AGC_OFS_FILT;
    assign cmd_idx7 = cmd_reg[6:0] - `AGC_OFS_FILT;
    assign rx_hit = rx_byte[6:0] >= `AGC_OFS_FILT
        && rx_byte[6:0] <= `AGC_OFS_SARDIAG;
    assign cmd_hit = cmd_reg[6:0] >= `AGC_OFS_FILT
        && cmd_reg[6:0] <= `AGC_OFS_SARDIAG;

    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        shin_next = shin_reg;
        shout_next = shout_reg;
        cmd_next = cmd_reg;
        regs_next = regs_reg;
        if (cs_s[1]) begin
            state_next = AGC_IDLE;
            bit_next = 4'h0;
        end else begin
            unique case (state_reg)
                AGC_IDLE: begin
                    state_next = AGC_CMD;
                    bit_next = 4'h0;
                end
                AGC_CMD: begin
                    if (sck_rise) begin
                        shin_next = rx_byte;
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == 4'h7) begin
                            cmd_next = rx_byte;
                            state_next = AGC_DATA;
                            // unmapped reads answer zero
                            shout_next = rx_hit
                                ? regs_reg[rx_idx7[2:0]] : 8'h00;
                        end
                    end
                end
                AGC_DATA: begin
                    if (sck_rise) begin
                        shin_next = rx_byte;
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == 4'hF) begin
                            state_next = AGC_DONE;
                            // whole byte kept, reserved bits too
                            if (!cmd_reg[7] && cmd_hit) begin
                                regs_next[cmd_idx7[2:0]] = rx_byte;
                            end
                        end
                    end
                    if (sck_fall && bit_reg != 4'h8) begin
                        shout_next = {shout_reg[6:0], 1'b0};
                    end
                end
                AGC_DONE: begin
                    state_next = AGC_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= AGC_IDLE;
            bit_reg <= 4'h0;
            shin_reg <= 8'h00;
            shout_reg <= 8'h00;
            cmd_reg <= 8'h00;
            regs_reg[0] <= `AGC_RST_FILT;
            regs_reg[1] <= `AGC_RST_SARPIN;
            regs_reg[2] <= `AGC_RST_FMT;
            regs_reg[3] <= `AGC_RST_REFMTR;
            regs_reg[4] <= `AGC_RST_SARDIAG;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            shin_reg <= shin_next;
            shout_reg <= shout_next;
            cmd_reg <= cmd_next;
            regs_reg <= regs_next;
        end
    end

    // ------------------------------------------------------------------
    // conversion start deglitch
    // ------------------------------------------------------------------
    logic [1:0] dgl_code;
    logic [1:0] dcnt_reg, dcnt_next;
    logic conv_reg, conv_next;
    assign dgl_code = regs_reg[1][`AGC_SARPIN_DGL_HI:`AGC_SARPIN_DGL_LO];

    always_comb begin
        dcnt_next = 2'h0;
        conv_next = conv_reg;
        // reserved codes behave like the filtered setting
        if (dgl_code == `AGC_DGL_NONE) begin
            conv_next = conv_s[1];
        end else if (conv_s[1] != conv_reg) begin
            dcnt_next = dcnt_reg + 2'h1;
            if (dcnt_next >= 2'(`AGC_DGL_CYC)) begin
                conv_next = conv_s[1];
                dcnt_next = 2'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // data clock divider and registered outputs
    // ------------------------------------------------------------------
    agc_div_if div_bus ();
    assign div_bus.div_code = regs_reg[2][`AGC_FMT_DIV_HI:`AGC_FMT_DIV_LO];

    agc_clk_div u_div (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .dv(div_bus.div)
    );

    logic [1:0] lane_code;
    logic [2:0] lanes_next;
    logic sdo_next;
    assign lane_code = regs_reg[2][`AGC_FMT_LANE_HI:`AGC_FMT_LANE_LO];

    always_comb begin
        unique case (lane_code)
            2'h0: lanes_next = `AGC_LANES_4;
            2'h1: lanes_next = `AGC_LANES_2;
            default: lanes_next = `AGC_LANES_1;
        endcase
        // register readback wins; SAR stream outranks ADC stream
        if (state_reg == AGC_DATA && cmd_reg[7]) begin
            sdo_next = shout_reg[7];
        end else if (cs_s[1]) begin
            sdo_next = 1'b0;
        end else if (regs_reg[0][`AGC_FILT_SARRB_BIT]) begin
            sdo_next = sar_result_bit_i;
        end else if (regs_reg[1][`AGC_SARPIN_ADCRB_BIT]) begin
            sdo_next = adc_result_bit_i;
        end else begin
            sdo_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dcnt_reg <= 2'h0;
            conv_reg <= 1'b0;
            serial_data_out_o <= 1'b0;
            filter_sinc5_o <= 1'b0;
            sar_readback_enable_o <= 1'b0;
            adc_readback_enable_o <= 1'b0;
            sync_in_b_o <= 1'b0;
            conv_start_o <= 1'b0;
            clock_ok_o <= 1'b0;
            active_lanes_o <= `AGC_LANES_4;
            header_crc_o <= 1'b1;
            data_clock_tick_o <= 1'b0;
            serial_out_drive_level_o <= 2'h1;
            lane_drive_level_o <= 2'h0;
            ref_sel_o <= 2'h0;
            meter_source_sel_o <= 4'h0;
            sar_mux_sel_o <= 5'h00;
        end else begin
            dcnt_reg <= dcnt_next;
            conv_reg <= conv_next;
            serial_data_out_o <= sdo_next;
            filter_sinc5_o <= regs_reg[0][`AGC_FILT_SINC5_BIT];
            sar_readback_enable_o <= regs_reg[0][`AGC_FILT_SARRB_BIT];
            adc_readback_enable_o <= regs_reg[1][`AGC_SARPIN_ADCRB_BIT];
            sync_in_b_o <= regs_reg[0][`AGC_FILT_SYNC_BIT]
                & start_s[1];
            conv_start_o <= conv_reg;
            // needed below 265 kHz where the qualifier cannot lock
            clock_ok_o <= regs_reg[1][`AGC_SARPIN_CKBYP_BIT]
                | mclk_s[1];
            active_lanes_o <= lanes_next;
            header_crc_o <= regs_reg[2][`AGC_FMT_CRC_BIT];
            data_clock_tick_o <= div_bus.tick;
            serial_out_drive_level_o <=
                regs_reg[0][`AGC_FILT_SDODRV_HI:`AGC_FILT_SDODRV_LO];
            lane_drive_level_o <=
                regs_reg[0][`AGC_FILT_LANEDRV_HI:`AGC_FILT_LANEDRV_LO];
            ref_sel_o <= regs_reg[3][`AGC_REF_HI:`AGC_REF_LO];
            meter_source_sel_o <=
                regs_reg[3][`AGC_MTR_HI:`AGC_MTR_LO];
            // raw code: downstream mux owns the one-source-per-code map
            sar_mux_sel_o <=
                regs_reg[4][`AGC_SARMUX_HI:`AGC_SARMUX_LO];
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    filter_select_a: assert property (
        ##1 filter_sinc5_o == $past(regs_reg[0][`AGC_FILT_SINC5_BIT]))
        else $error("filter output does not follow its bit");
    sar_route_a: assert property (
        regs_reg[0][`AGC_FILT_SARRB_BIT] && !cs_s[1]
        && state_reg != AGC_DATA
        |=> serial_data_out_o == $past(sar_result_bit_i))
        else $error("SAR result not on serial out");
    sync_and_a: assert property (
        ##1 sync_in_b_o == ($past(regs_reg[0][0]) & $past(start_s[1])))
        else $error("sync output is not the AND");
    deglitch_bypass_a: assert property (
        dgl_code == `AGC_DGL_NONE && $stable(dgl_code)
        && $changed(conv_s[1])
        |-> ##2 conv_start_o == $past(conv_s[1], 2))
        else $error("unfiltered start was delayed");
    deglitch_short_a: assert property (
        dgl_code == 2'h2 && $stable(dgl_code) && conv_s[1] != conv_reg
        && $past(conv_s[1]) == conv_reg |=> conv_reg == $past(conv_reg))
        else $error("one-cycle glitch passed the filter");
    adc_route_a: assert property (
        !regs_reg[0][`AGC_FILT_SARRB_BIT]
        && regs_reg[1][`AGC_SARPIN_ADCRB_BIT] && !cs_s[1]
        && state_reg != AGC_DATA
        |=> serial_data_out_o == $past(adc_result_bit_i))
        else $error("ADC result not on serial out");
    clock_bypass_a: assert property (
        regs_reg[1][0] |=> clock_ok_o)
        else $error("bypass did not accept the clock");
    lane_decode_a: assert property (
        lane_code == 2'h3 |=> active_lanes_o == `AGC_LANES_1)
        else $error("code 11 must give one lane");
    header_sel_a: assert property (
        !regs_reg[2][`AGC_FMT_CRC_BIT] |=> !header_crc_o)
        else $error("status header not selected");
    ref_follow_a: assert property (
        ##1 ref_sel_o == $past(regs_reg[3][7:6]))
        else $error("reference select lags its field");
    reserved_keep_a: assert property (
        state_reg == AGC_DATA && sck_rise
        && bit_reg == 4'hF && !cmd_reg[7] && cmd_reg[6:0] == `AGC_OFS_FMT
        |=> regs_reg[2] == $past(rx_byte))
        else $error("written byte not stored whole");

    write_seen_c: cover property (state_reg == AGC_DATA && sck_rise
        && bit_reg == 4'hF && !cmd_reg[7] && cmd_hit);
    read_seen_c: cover property (state_reg == AGC_DATA && cmd_reg[7]);
    sync_pulse_c: cover property (sync_in_b_o ##1 !sync_in_b_o);
    glitch_c: cover property (dgl_code == 2'h2 && conv_s[1] != conv_reg);
endmodule : agc_regs

//--- tb/tb_top.sv
// self-checking bench for the general configuration register bank
`timescale 1ns/10ps
`include "agc_cfg.svh"
module tb_top
    import agc_pkg::*;
;
    // ------------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ------------------------------------------------------------------
    logic clk, rst_b, cs_b, sclk, mosi, start_b, cpin, mvalid, sar_b, adc_b;
    logic serial_data_out, sinc5, sar_en, adc_en, sync_b, conv, ck_ok, crc, tick, s;
    logic [2:0] lanes, kb;
    logic [1:0] sdrv, ldrv, refs;
    logic [3:0] mtr;
    logic [4:0] smux;
    agc_byte_t exp_q[$], got_q[$], q, d;
    agc_byte_t rv[5] = '{`AGC_RST_FILT, `AGC_RST_SARPIN, `AGC_RST_FMT,
        `AGC_RST_REFMTR, `AGC_RST_SARDIAG};
    logic [15:0] lfsr_st;
    int failures, compares, i, k, c;

    agc_regs dut (.clk_i(clk), .rst_b_i(rst_b), .spi_cs_b_i(cs_b),
        .spi_sclk_i(sclk), .spi_mosi_i(mosi), .start_pin_b_i(start_b),
        .sar_conv_start_pin_i(cpin), .mclk_valid_i(mvalid),
        .sar_result_bit_i(sar_b), .adc_result_bit_i(adc_b),
        .serial_data_out_o(serial_data_out), .filter_sinc5_o(sinc5),
        .sar_readback_enable_o(sar_en), .adc_readback_enable_o(adc_en),
        .sync_in_b_o(sync_b), .conv_start_o(conv), .clock_ok_o(ck_ok),
        .active_lanes_o(lanes), .header_crc_o(crc),
        .data_clock_tick_o(tick), .serial_out_drive_level_o(sdrv),
        .lane_drive_level_o(ldrv), .ref_sel_o(refs),
        .meter_source_sel_o(mtr), .sar_mux_sel_o(smux));

    always #25 clk = ~clk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic agc_byte_t rnd();
        lfsr_st = {lfsr_st[14:0],
            lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st[7:0];
    endfunction : rnd

    task note(input agc_byte_t g, input agc_byte_t e);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask : note

    task note1(input logic g, input logic e);
        note({7'h0, g}, {7'h0, e});
    endtask : note1

    task cmp(input agc_byte_t g, input agc_byte_t e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    // watcher: oldest expectation against oldest result
    always @(posedge clk) begin
        if (got_q.size() > 0) cmp(got_q.pop_front(), exp_q.pop_front());
    end

    // 16-bit frame, msb first, half period of 5 clocks
    task spi(input logic rd, input logic [6:0] a, input agc_byte_t dt,
        output agc_byte_t r);
        logic [15:0] w;
        w = {rd, a, dt};
        r = 8'h00;
        @(posedge clk) cs_b <= 1'b0;
        repeat (3) @(posedge clk);
        for (int b = 15; b >= 0; b--) begin
            mosi <= w[b];
            repeat (4) @(posedge clk);
            @(negedge clk);
            if (b < 8) r[b] = serial_data_out;
            @(posedge clk) sclk <= 1'b1;
            repeat (5) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        cs_b <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : spi

    task pulse_win(output logic seen);
        @(posedge clk) cpin <= 1'b1;
        @(posedge clk) cpin <= 1'b0;
        seen = 1'b0;
        repeat (10) begin
            @(negedge clk);
            seen = seen | conv;
        end
    endtask : pulse_win

    // chip select low with no clocking: output follows the chosen stream
    task stream(input logic use_sar);
        agc_byte_t v;
        @(posedge clk) cs_b <= 1'b0;
        // cs needs two clocks through the synchroniser before data counts
        repeat (2) @(posedge clk);
        repeat (8) begin
            v = rnd();
            @(posedge clk);
            sar_b <= v[0];
            adc_b <= v[1];
            @(posedge clk);
            @(negedge clk);
            note1(serial_data_out, use_sar ? v[0] : v[1]);
        end
        @(posedge clk) cs_b <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        note1(serial_data_out, 1'b0);
    endtask : stream

    task tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {clk, rst_b, sclk, mosi, cpin, mvalid, sar_b, adc_b} = '0;
        {cs_b, start_b} = 2'b11;
        failures = 0;
        compares = 0;
        lfsr_st = 16'hE174;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        note({5'h0, lanes}, 8'h04);
        note1(crc, 1'b1);
        note1(sinc5, 1'b0);
        note1(sync_b, 1'b1);
        note({4'h0, sdrv, ldrv}, 8'h04);
        for (i = 0; i < 5; i++) begin
            spi(1'b1, 7'(`AGC_OFS_FILT + i), 8'h00, q);
            note(q, rv[i]);
        end
        spi(1'b0, 7'h17, 8'hFF, q);
        spi(1'b1, 7'h17, 8'h00, q);
        note(q, 8'h00);
        spi(1'b1, 7'h11, 8'h00, q);
        note(q, 8'h00);
        for (i = 0; i < 10; i++) begin
            d = rnd();
            spi(1'b0, 7'(`AGC_OFS_FILT + i % 5), d, q);
            spi(1'b1, 7'(`AGC_OFS_FILT + i % 5), 8'h00, q);
            note(q, d);
            @(negedge clk);
            case (i % 5)
                0: begin
                    note1(sinc5, d[6]);
                    note1(sar_en, d[5]);
                    note({4'h0, sdrv, ldrv}, {4'h0, d[4:1]});
                    note1(sync_b, d[0]);
                end
                1: begin
                    note1(adc_en, d[4]);
                    note1(ck_ok, d[0]);
                end
                3: begin
                    note({6'h0, refs}, {6'h0, d[7:6]});
                    note({4'h0, mtr}, {4'h0, d[5:2]});
                end
                4: note({smux, 3'h0}, {d[7:3], 3'h0});
                default: ;
            endcase
        end
        for (k = 0; k < 8; k++) begin
            kb = 3'(k);
            spi(1'b0, `AGC_OFS_FMT, {kb[1:0], kb[0], 1'b0, kb, 1'b0}, q);
            @(negedge clk);
            note({5'h0, lanes}, kb[1:0] == 2'b00 ? 8'h04 :
                (kb[1:0] == 2'b01 ? 8'h02 : 8'h01));
            note1(crc, kb[0]);
            c = 0;
            repeat (128) begin
                @(negedge clk);
                c = c + ((tick === 1'b1) ? 1 : 0);
            end
            note(8'(c), 8'(128 >> k));
        end
        spi(1'b0, `AGC_OFS_FILT, 8'h09, q);
        spi(1'b0, `AGC_OFS_SARPIN, 8'h80, q);
        start_b <= 1'b0;
        mvalid <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        note1(sync_b, 1'b0);
        note1(ck_ok, 1'b1);
        @(posedge clk);
        start_b <= 1'b1;
        mvalid <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        note1(sync_b, 1'b1);
        note1(ck_ok, 1'b0);
        // a one-clock glitch must be filtered, a held level accepted
        pulse_win(s);
        note1(s, 1'b0);
        @(posedge clk) cpin <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        note1(conv, 1'b1);
        @(posedge clk) cpin <= 1'b0;
        spi(1'b0, `AGC_OFS_SARPIN, 8'hC0, q);
        pulse_win(s);
        note1(s, 1'b1);
        spi(1'b0, `AGC_OFS_FILT, 8'h29, q);
        stream(1'b1);
        spi(1'b0, `AGC_OFS_FILT, 8'h09, q);
        spi(1'b0, `AGC_OFS_SARPIN, 8'h90, q);
        stream(1'b0);
        for (i = 0; i < 200 && got_q.size() > 0; i++) @(posedge clk);
        if (got_q.size() > 0) failures++;
        tally_and_finish();
    end
endmodule : tb_top
